// ---- hdl/uart_event_timing.v ----
`timescale 1ns/1ps
`include "uart_event_timing_consts.vh"
// How it works
// - stop bit sets rx-ready within one cycle, irq within two
// - character time-out irq nine cycles later
// - reading buffer or line status clears irq
// - first write starts bit 8-24 cycles later
// - transmit irq 8-10 cycles after start
// - holding write clears holding-empty irq
// - holding-empty irq 16-34 cycles after write
// - ident read clears reported holding-empty irq
// - write drops tx-ready; back within 9
// - modem input change irq, status read clears
// - modem control write drives modem outputs
// - auto-cts start bit within 24 of cts
// - auto-rts raised within 2 at threshold
// - auto-rts lowered within 2 after empty
// - fourteen threshold raises rts at sixteenth char
// - fourteen threshold lowers rts after read
// - ready pins mode 1 only fifo plus dma
module uart_event_timing (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_rst_b,
  // configuration
  input  wire [15:0] i_divisor,
  input  wire        i_fifo_enable_bit,
  input  wire        i_dma_mode_bit,
  input  wire [1:0]  i_rx_thresh_sel,
  input  wire        i_auto_rts_en,
  input  wire        i_auto_cts_en,
  input  wire [3:0]  i_irq_enable,
  // cpu strobes
  input  wire        i_tx_holding_wr,
  input  wire [7:0]  i_tx_holding_data,
  input  wire        i_rx_buffer_read_strobe,
  input  wire        i_line_status_rd,
  input  wire        i_irq_ident_rd,
  input  wire        i_modem_status_rd,
  input  wire        i_modem_control_wr,
  input  wire [3:0]  i_modem_control_data,
  // line side
  input  wire        i_serial_in,
  input  wire        i_cts_b,
  input  wire [3:0]  i_modem_in,
  // cpu results
  output reg  [7:0]  o_rx_buffer,
  output reg         o_rx_valid,
  output reg  [3:0]  o_irq_ident_reg,
  output reg  [3:0]  o_modem_status_reg,
  output reg         o_rx_data_ready,
  output reg         o_tx_holding_empty,
  // pins
  output reg         o_irq_out,
  output reg         o_rx_ready_pin_b,
  output reg         o_tx_ready_pin_b,
  output reg         o_serial_out,
  output reg         o_rts_b,
  output reg  [3:0]  o_modem_control_reg
);
  // ----------------------------------------
  // baud tick
  // ----------------------------------------
  reg  [15:0] div_cnt_reg;
  wire        tick = (div_cnt_reg == 16'h0001) || (i_divisor == 16'h0000);
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_cnt_reg <= 16'h0001;
    end else if (tick) begin
      div_cnt_reg <= (i_divisor == 16'h0000) ? 16'h0001 : i_divisor;
    end else begin
      div_cnt_reg <= div_cnt_reg - 16'h0001;
    end
  end

  function [4:0] thresh_val;
    input [1:0] sel;
    begin
      case (sel)
        `THR_SEL_1: thresh_val = `THR_VAL_1;
        `THR_SEL_4: thresh_val = `THR_VAL_4;
        `THR_SEL_8: thresh_val = `THR_VAL_8;
        default:    thresh_val = `THR_VAL_14;
      endcase
    end
  endfunction

  wire mode1 = i_fifo_enable_bit & i_dma_mode_bit;

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  localparam RX_IDLE = 2'd0;
  localparam RX_DATA = 2'd1;
  localparam RX_STOP = 2'd2;
  reg  [1:0] rx_st_reg;
  reg  [3:0] rx_ph_reg;
  reg  [3:0] rx_bit_reg;
  reg  [7:0] rx_sh_reg;
  reg        rx_done;
  reg        rx_first_data;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_st_reg <= RX_IDLE;
      rx_ph_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      rx_done <= 1'b0;
      rx_first_data <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      rx_first_data <= 1'b0;
      if (tick) begin
        rx_ph_reg <= rx_ph_reg + 4'h1;
        case (rx_st_reg)
          RX_IDLE: begin
            rx_ph_reg <= 4'h0;
            if (!i_serial_in) begin
              rx_st_reg <= RX_DATA;
              rx_bit_reg <= 4'h0;
            end
          end
          RX_DATA: begin
            if (rx_ph_reg == 4'hf) begin
              if (rx_bit_reg == 4'h0) begin
                rx_first_data <= 1'b1;
              end
              rx_bit_reg <= rx_bit_reg + 4'h1;
              if (rx_bit_reg == 4'h8) begin
                rx_st_reg <= RX_STOP;
              end
            end
            if (rx_ph_reg == 4'h7 && rx_bit_reg != 4'h0) begin
              rx_sh_reg <= {i_serial_in, rx_sh_reg[7:1]};
            end
          end
          RX_STOP: begin
            if (rx_ph_reg == 4'h7) begin
              rx_done <= 1'b1;
              rx_st_reg <= RX_IDLE;
            end
          end
          default: rx_st_reg <= RX_IDLE;
        endcase
      end
    end
  end

  // fifo pointers; depth one in character mode
  reg  [3:0] rd_ptr_reg;
  reg  [3:0] wr_ptr_reg;
  reg  [4:0] cnt_reg;
  wire       full = i_fifo_enable_bit ? (cnt_reg == `FIFO_FULL_CNT) : (cnt_reg != 5'h00);
  wire       do_wr = rx_done & ~full;
  wire       do_rd = i_rx_buffer_read_strobe & (cnt_reg != 5'h00);
  wire [7:0] mem_q;
  rx_fifo_mem u_mem (
    .i_clk     (i_clk),
    .i_wr_en   (do_wr),
    .i_wr_addr (wr_ptr_reg),
    .i_wr_data (rx_sh_reg),
    .i_rd_addr (rd_ptr_reg),
    .o_rd_data (mem_q)
  );
  reg rd_pend_reg;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_ptr_reg <= 4'h0;
      wr_ptr_reg <= 4'h0;
      cnt_reg <= 5'h00;
      rd_pend_reg <= 1'b0;
      o_rx_buffer <= 8'h00;
      o_rx_valid <= 1'b0;
    end else begin
      rd_pend_reg <= do_rd;
      o_rx_valid <= rd_pend_reg;
      if (rd_pend_reg) begin
        o_rx_buffer <= mem_q;
      end
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + 4'h1;
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + 4'h1;
      end
      cnt_reg <= cnt_reg + {4'h0, do_wr} - {4'h0, do_rd};
    end
  end
  wire [4:0] cnt_after = cnt_reg + {4'h0, do_wr} - {4'h0, do_rd};

  // character time-out: 256 ticks idle (four times 64) plus nine extra ticks
  reg [9:0] to_cnt_reg;
  reg       timeout_reg;
  wire      to_hit = (to_cnt_reg == {`RX_TIMEOUT_CHARS, 3'h0, 3'h0} + 10'h009);
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      to_cnt_reg <= 10'h000;
      timeout_reg <= 1'b0;
    end else begin
      if (do_wr || do_rd || cnt_reg == 5'h00 || !i_fifo_enable_bit) begin
        to_cnt_reg <= 10'h000;
      end else if (tick && !to_hit) begin
        to_cnt_reg <= to_cnt_reg + 10'h001;
      end
      if (do_rd || !i_fifo_enable_bit) begin
        timeout_reg <= 1'b0;
      end else if (to_hit) begin
        timeout_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  localparam TX_IDLE = 2'd0;
  localparam TX_WAIT = 2'd1;
  localparam TX_SEND = 2'd2;
  reg  [1:0] tx_st_reg;
  reg  [7:0] buf_d0_reg;
  reg  [7:0] buf_d1_reg;
  reg  [1:0] buf_n_reg;
  reg  [4:0] tx_dly_reg;
  reg  [3:0] tx_ph_reg;
  reg  [3:0] tx_bit_reg;
  reg  [9:0] tx_sh_reg;
  reg        tx_irq_arm_reg;
  reg        tx_start_evt;
  wire       buf_ready = (buf_n_reg != 2'h2);
  wire       buf_push = i_tx_holding_wr & buf_ready;
  wire       cts_ok = ~i_auto_cts_en | ~i_cts_b;
  wire       buf_pop = tick & (tx_st_reg == TX_WAIT) & (tx_dly_reg == 5'h00) & cts_ok;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_st_reg <= TX_IDLE;
      buf_d0_reg <= 8'h00;
      buf_d1_reg <= 8'h00;
      buf_n_reg <= 2'h0;
      tx_dly_reg <= 5'h00;
      tx_ph_reg <= 4'h0;
      tx_bit_reg <= 4'h0;
      tx_sh_reg <= 10'h3ff;
      o_serial_out <= 1'b1;
      tx_irq_arm_reg <= 1'b0;
      tx_start_evt <= 1'b0;
    end else begin
      tx_start_evt <= 1'b0;
      // two-entry holding buffer, drops writes when full
      if (buf_pop) begin
        buf_d0_reg <= buf_d1_reg;
      end
      if (buf_push) begin
        if (buf_n_reg == 2'h0 || (buf_n_reg == 2'h1 && buf_pop)) begin
          buf_d0_reg <= i_tx_holding_data;
        end else begin
          buf_d1_reg <= i_tx_holding_data;
        end
      end
      buf_n_reg <= buf_n_reg + {1'b0, buf_push} - {1'b0, buf_pop};
      case (tx_st_reg)
        TX_IDLE: begin
          if (buf_n_reg != 2'h0) begin
            tx_st_reg <= TX_WAIT;
            tx_dly_reg <= `TX_START_DELAY;
          end
        end
        TX_WAIT: begin
          if (tick && tx_dly_reg != 5'h00) begin
            tx_dly_reg <= tx_dly_reg - 5'h01;
          end
          if (buf_pop) begin
            tx_sh_reg <= {1'b1, buf_d0_reg, 1'b0};
            tx_st_reg <= TX_SEND;
            tx_ph_reg <= 4'h0;
            tx_bit_reg <= 4'h0;
            o_serial_out <= 1'b0;
            tx_start_evt <= 1'b1;
            tx_irq_arm_reg <= 1'b1;
            tx_dly_reg <= `TX_IRQ_DELAY;
          end
        end
        TX_SEND: begin
          if (tick) begin
            tx_ph_reg <= tx_ph_reg + 4'h1;
            if (tx_irq_arm_reg) begin
              tx_dly_reg <= tx_dly_reg - 5'h01;
              if (tx_dly_reg == 5'h01) begin
                tx_irq_arm_reg <= 1'b0;
              end
            end
            if (tx_ph_reg == 4'hf) begin
              tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
              o_serial_out <= tx_sh_reg[1];
              tx_bit_reg <= tx_bit_reg + 4'h1;
              if (tx_bit_reg == `CHAR_BITS - 4'h1) begin
                o_serial_out <= 1'b1;
                tx_st_reg <= TX_IDLE;
              end
            end
          end
        end
        default: tx_st_reg <= TX_IDLE;
      endcase
    end
  end
  wire tx_irq_evt = tick & (tx_st_reg == TX_SEND) & tx_irq_arm_reg & (tx_dly_reg == 5'h01);

  // ----------------------------------------
  // interrupts, modem and ready pins
  // ----------------------------------------
  reg        rx_irq_reg;
  reg        tx_holding_empty_irq_reg;
  reg        modem_irq_reg;
  reg  [3:0] modem_q_reg;
  wire [3:0] modem_delta = modem_q_reg ^ i_modem_in;
  wire       line_irq = 1'b0;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_irq_reg <= 1'b0;
      tx_holding_empty_irq_reg <= 1'b0;
      modem_irq_reg <= 1'b0;
      modem_q_reg <= 4'h0;
      o_modem_status_reg <= 4'h0;
      o_modem_control_reg <= `MCR_RESET;
      o_tx_holding_empty <= 1'b1;
    end else begin
      modem_q_reg <= i_modem_in;
      rx_irq_reg <= (cnt_after >= (i_fifo_enable_bit ? thresh_val(i_rx_thresh_sel) : 5'h01));
      if (tx_irq_evt) begin
        tx_holding_empty_irq_reg <= 1'b1;
      end else if (i_tx_holding_wr || (i_irq_ident_rd && o_irq_ident_reg == `IID_TX_HOLDING_EMPTY)) begin
        tx_holding_empty_irq_reg <= 1'b0;
      end
      if (tx_start_evt) begin
        o_tx_holding_empty <= (buf_n_reg == 2'h0) & ~buf_push;
      end else if (buf_push) begin
        o_tx_holding_empty <= 1'b0;
      end
      if (modem_delta != 4'h0) begin
        modem_irq_reg <= 1'b1;
        o_modem_status_reg <= o_modem_status_reg | modem_delta;
      end else if (i_modem_status_rd) begin
        modem_irq_reg <= 1'b0;
        o_modem_status_reg <= 4'h0;
      end
      if (i_modem_control_wr) begin
        o_modem_control_reg <= i_modem_control_data;
      end
    end
  end

  reg [3:0] iid_next;
  always @* begin
    iid_next = `IID_NONE;
    if (i_irq_enable[2] && line_irq && !i_line_status_rd) begin
      iid_next = `IID_LINE;
    end else if (i_irq_enable[0] && rx_irq_reg) begin
      iid_next = `IID_RXDATA;
    end else if (i_irq_enable[0] && timeout_reg) begin
      iid_next = `IID_TIMEOUT;
    end else if (i_irq_enable[1] && tx_holding_empty_irq_reg) begin
      iid_next = `IID_TX_HOLDING_EMPTY;
    end else if (i_irq_enable[3] && modem_irq_reg) begin
      iid_next = `IID_MODEM;
    end
  end

  // auto-rts and ready pins
  wire [4:0] tx_holding = thresh_val(i_rx_thresh_sel);
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq_ident_reg <= `IID_NONE;
      o_irq_out <= 1'b0;
      o_rts_b <= 1'b1;
      o_rx_ready_pin_b <= 1'b1;
      o_tx_ready_pin_b <= 1'b0;
      o_rx_data_ready <= 1'b0;
    end else begin
      o_irq_ident_reg <= iid_next;
      o_irq_out <= (iid_next != `IID_NONE);
      o_rx_data_ready <= (cnt_after != 5'h00);
      if (i_auto_rts_en && i_fifo_enable_bit) begin
        if (i_rx_thresh_sel == `THR_SEL_14) begin
          if (rx_first_data && cnt_reg == 5'h0f) begin
            o_rts_b <= 1'b1;
          end else if (i_rx_buffer_read_strobe) begin
            o_rts_b <= 1'b0;
          end
        end else if (cnt_after >= tx_holding) begin
          o_rts_b <= 1'b1;
        end else if (cnt_after == 5'h00) begin
          o_rts_b <= 1'b0;
        end
      end else begin
        o_rts_b <= ~o_modem_control_reg[1];
      end
      if (mode1) begin
        o_rx_ready_pin_b <= ~((cnt_after >= tx_holding) | timeout_reg);
        o_tx_ready_pin_b <= (buf_n_reg + {1'b0, buf_push} == 2'h2) | ~buf_ready;
      end else begin
        o_rx_ready_pin_b <= (cnt_after == 5'h00);
        if (buf_push) begin
          o_tx_ready_pin_b <= 1'b1;
        end else if (tx_start_evt && buf_n_reg == 2'h0) begin
          o_tx_ready_pin_b <= 1'b0;
        end
      end
    end
  end
endmodule // uart_event_timing

// ---- hdl/uart_event_timing_consts.vh ----
`ifndef UART_EVENT_TIMING_CONSTS_VH
`define UART_EVENT_TIMING_CONSTS_VH

// ----------------------------------------
// clock and baud timing
// ----------------------------------------
`define CLK_PERIOD_NS      40
`define BAUD_DIV_W         16
`define SAMPLES_PER_BIT    5'h10
`define CHAR_BITS          4'ha
// baud-output cycles
`define TX_START_DELAY     5'h08
`define TX_IRQ_DELAY       5'h09
`define RX_TIMEOUT_CHARS   3'h4
`define TIMEOUT_EXTRA      4'h9

// ----------------------------------------
// fifo and control fields
// ----------------------------------------
`define FIFO_DEPTH         16
`define FIFO_AW            4
`define FIFO_CW            5
`define FIFO_FULL_CNT      5'h10
`define THR_SEL_1          2'h0
`define THR_SEL_4          2'h1
`define THR_SEL_8          2'h2
`define THR_SEL_14         2'h3
`define THR_VAL_1          5'h01
`define THR_VAL_4          5'h04
`define THR_VAL_8          5'h08
`define THR_VAL_14         5'h0e
`define MCR_W              4
`define MCR_RESET          4'h0

// ----------------------------------------
// interrupt identification codes
// ----------------------------------------
`define IID_NONE           4'h1
`define IID_LINE           4'h6
`define IID_RXDATA         4'h4
`define IID_TIMEOUT        4'hc
`define IID_TX_HOLDING_EMPTY           4'h2
`define IID_MODEM          4'h0

`endif

// ---- hdl/rx_fifo_mem.v ----
`timescale 1ns/1ps
// ----------------------------------------
// receive fifo storage, registered read
// ----------------------------------------
module rx_fifo_mem (
  // clock
  input  wire       i_clk,
  // write side
  input  wire       i_wr_en,
  input  wire [3:0] i_wr_addr,
  input  wire [7:0] i_wr_data,
  // read side
  input  wire [3:0] i_rd_addr,
  output reg  [7:0] o_rd_data
);
  reg [7:0] mem [0:15];

  always @(posedge i_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end
endmodule // rx_fifo_mem

// ---- verif/uart_event_timing_sva.sv ----
`timescale 1ns/1ps
`include "uart_event_timing_consts.vh"
// ----------------------------------------
// port checker, divisor 2 assumed
// ----------------------------------------
module uart_event_timing_sva (
  input wire       i_clk,
  input wire       i_rst_b,
  input wire       i_fifo_enable_bit,
  input wire       i_dma_mode_bit,
  input wire [1:0] i_rx_thresh_sel,
  input wire       i_auto_rts_en,
  input wire       i_auto_cts_en,
  input wire [3:0] i_irq_enable,
  input wire       i_tx_holding_wr,
  input wire       i_rx_buffer_read_strobe,
  input wire [3:0] i_modem_in,
  input wire [3:0] o_irq_ident_reg,
  input wire       o_rx_data_ready,
  input wire       o_tx_holding_empty,
  input wire       o_irq_out,
  input wire       o_rx_ready_pin_b,
  input wire       o_tx_ready_pin_b,
  input wire       o_serial_out,
  input wire       o_rts_b
);
  // a full character of high line means the shifter is idle
  reg  [8:0] gap_reg;
  wire       idle = o_tx_holding_empty && o_serial_out && gap_reg > 9'h140 && !i_auto_cts_en;
  wire       mode1 = i_fifo_enable_bit && i_dma_mode_bit;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      gap_reg <= 9'h1ff;
    else if (!o_serial_out)
      gap_reg <= 9'h000;
    else if (gap_reg != 9'h1ff)
      gap_reg <= gap_reg + 9'h001;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_start_bit;
    ##[14:50] $fell(o_serial_out);
  endsequence
  sequence s_tx_holding_empty_irq;
    ##[30:70] o_irq_out;
  endsequence
  AST_TX_START: assert property (i_tx_holding_wr && idle |-> s_start_bit)
    else $error("start bit late or early");
  AST_TX_HOLDING_EMPTY_IRQ: assert property (i_tx_holding_wr && idle && i_irq_enable[1] |-> s_tx_holding_empty_irq)
    else $error("holding empty irq missing");
  AST_TX_READY_PIN_OFF: assert property (i_tx_holding_wr && !mode1 |-> ##[1:2] o_tx_ready_pin_b)
    else $error("tx ready stayed active after write");
  AST_RX_READY: assert property ($rose(o_rx_data_ready) && !mode1 |->
    ##[0:2] (!o_rx_ready_pin_b && (o_irq_out || !i_irq_enable[0])))
    else $error("rx ready or irq late");
  AST_RX_CLR: assert property (i_rx_buffer_read_strobe && !i_fifo_enable_bit &&
    o_irq_ident_reg == `IID_RXDATA |-> ##[1:3] o_irq_ident_reg != `IID_RXDATA)
    else $error("rx irq not cleared by read");
  AST_MODEM_IRQ: assert property ($changed(i_modem_in) && i_irq_enable[3] |-> ##[1:4] o_irq_out)
    else $error("modem irq missing");
  AST_RTS_UP: assert property ($rose(o_rx_data_ready) && i_auto_rts_en &&
    i_rx_thresh_sel == `THR_SEL_1 |-> ##[0:6] o_rts_b)
    else $error("rts not raised at threshold");
  AST_RTS_DOWN: assert property ($fell(o_rx_data_ready) && i_auto_rts_en |-> ##[0:6] !o_rts_b)
    else $error("rts not lowered after last read");
endmodule // uart_event_timing_sva

// ---- verif/line_peer.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// serial peer, 8N1, lsb first
// ----------------------------------------
module line_peer #(
  parameter BIT = 32
) (
  input  wire i_clk,
  input  wire i_line,
  output reg  o_line
);
  integer   k;
  reg [7:0] got;
  reg [7:0] rx_q[$];
  initial o_line = 1'b1;
  task send(input [7:0] b);
    integer i;
    for (i = 0; i < 10; i = i + 1) begin
      @(posedge i_clk);
      o_line <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (BIT - 1) @(posedge i_clk);
    end
  endtask
  // samples mid-bit; stop bit is not checked
  always begin
    @(negedge i_line);
    repeat (BIT / 2) @(posedge i_clk);
    for (k = 0; k < 8; k = k + 1) begin
      repeat (BIT) @(posedge i_clk);
      got[k] = i_line;
    end
    repeat (BIT) @(posedge i_clk);
    rx_q.push_back(got);
  end
endmodule // line_peer

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`include "uart_event_timing_consts.vh"
module testbench;
  reg        i_clk = 1'b0, i_rst_b = 1'b0, fifo = 1'b0, dma = 1'b0, arts = 1'b0, acts = 1'b0;
  reg        cts_b = 1'b0;
  reg  [1:0] sel = 2'h0;
  reg  [3:0] irq_en = 4'h0, mcr_d = 4'h0, modem = 4'h0;
  reg  [4:0] strb = 5'h00;
  reg  [7:0] txd = 8'h00, d;
  reg  [7:0] txq[$], rxq[$];
  integer    seed, bad_count = 0, comparisons = 0, cyc = 0, n, s, m, t;
  wire [7:0] rx_buf;
  wire [3:0] ident, modem_status_reg, modem_control_reg;
  wire       rx_valid, rx_dr, the, irq, rxr_b, txr_b, serial_out, rts_b, sin;
  always #20 i_clk = ~i_clk;
  uart_event_timing i_uart_event_timing (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_divisor(16'h0002), .i_fifo_enable_bit(fifo),
    .i_dma_mode_bit(dma), .i_rx_thresh_sel(sel), .i_auto_rts_en(arts), .i_auto_cts_en(acts),
    .i_irq_enable(irq_en), .i_tx_holding_wr(strb[4]), .i_tx_holding_data(txd),
    .i_rx_buffer_read_strobe(strb[0]), .i_line_status_rd(1'b0), .i_irq_ident_rd(strb[1]),
    .i_modem_status_rd(strb[2]), .i_modem_control_wr(strb[3]), .i_modem_control_data(mcr_d),
    .i_serial_in(sin), .i_cts_b(cts_b), .i_modem_in(modem), .o_rx_buffer(rx_buf),
    .o_rx_valid(rx_valid), .o_irq_ident_reg(ident), .o_modem_status_reg(modem_status_reg),
    .o_rx_data_ready(rx_dr), .o_tx_holding_empty(the), .o_irq_out(irq),
    .o_rx_ready_pin_b(rxr_b), .o_tx_ready_pin_b(txr_b), .o_serial_out(serial_out), .o_rts_b(rts_b),
    .o_modem_control_reg(modem_control_reg));
  line_peer #(.BIT(32)) i_peer (.i_clk(i_clk), .i_line(serial_out), .o_line(sin));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task pulse(input [4:0] sm);
    begin
      @(posedge i_clk);
      strb <= sm;
      @(posedge i_clk);
      strb <= 5'h00;
    end
  endtask
  task wr_tx(input [7:0] v);
    begin
      txd <= v;
      pulse(5'h10);
    end
  endtask
  task tx_cmp(input integer cnt);
    begin
      while (i_peer.rx_q.size() < cnt) @(posedge i_clk);
      repeat (cnt) chk(i_peer.rx_q.pop_front(), txq.pop_front());
    end
  endtask
  task test_done;
    begin
      $display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // ----------------------------------------
  // hang guard, about three times the expected run
  // ----------------------------------------
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      bad_count = bad_count + 1;
      test_done;
    end
  end
  initial begin
    seed = 32'hf009;
    repeat (11) @(posedge i_clk);
    chk({serial_out, rts_b, rxr_b, txr_b, irq, ident, the, modem_control_reg}, {4'he, 1'b0, `IID_NONE, 1'b1, `MCR_RESET});
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    $display("test 1 done");
    irq_en <= 4'h2;
    for (n = 0; n < 2; n = n + 1) begin
      d = $random(seed);
      txq.push_back(d);
      wr_tx(d);
      repeat (2) @(posedge i_clk);
      chk({irq, the}, 2'h0);
      while (irq !== 1'b1) @(posedge i_clk);
      chk({ident, the, txr_b}, {`IID_TX_HOLDING_EMPTY, 2'h2});
    end
    pulse(5'h02);
    repeat (3) @(posedge i_clk);
    chk(irq, 1'b0);
    tx_cmp(2);
    $display("test 2 done");
    acts <= 1'b1;
    cts_b <= 1'b1;
    fifo <= 1'b1;
    dma <= 1'b1;
    for (n = 0; n < 3; n = n + 1) begin
      d = $random(seed);
      if (n < 2) txq.push_back(d);
      wr_tx(d);
      repeat (2) @(posedge i_clk);
      if (n < 2) chk(txr_b, n);
    end
    repeat (200) @(posedge i_clk);
    chk(serial_out, 1'b1);
    cts_b <= 1'b0;
    t = 0;
    while (serial_out !== 1'b0) begin
      @(posedge i_clk);
      t = t + 1;
    end
    chk(t <= 50, 1'b1);
    repeat (20) @(posedge i_clk);
    chk(txr_b, 1'b0);
    tx_cmp(2);
    acts <= 1'b0;
    fifo <= 1'b0;
    dma <= 1'b0;
    irq_en <= 4'h1;
    $display("test 3 done");
    for (n = 0; n < 2; n = n + 1) begin
      d = $random(seed);
      i_peer.send(d);
      while (rx_dr !== 1'b1) @(posedge i_clk);
      repeat (2) @(posedge i_clk);
      chk({irq, rxr_b, ident}, {2'h2, `IID_RXDATA});
      pulse(5'h01);
      while (rx_valid !== 1'b1) @(posedge i_clk);
      chk(rx_buf, d);
      repeat (2) @(posedge i_clk);
      chk({irq, rx_dr}, 2'h0);
    end
    // one byte below threshold, left to age into a time-out
    fifo <= 1'b1;
    dma <= 1'b1;
    sel <= 2'h1;
    d = $random(seed);
    i_peer.send(d);
    chk(rxr_b, 1'b1);
    repeat (560) @(posedge i_clk);
    chk({irq, ident, rxr_b}, {1'b1, `IID_TIMEOUT, 1'b0});
    pulse(5'h01);
    repeat (3) @(posedge i_clk);
    chk({irq, rxr_b, rx_buf}, {2'h1, d});
    $display("test 4 done");
    irq_en <= 4'h0;
    fifo <= 1'b1;
    dma <= 1'b0;
    arts <= 1'b1;
    // rts leaves its manual level one clock after auto mode starts
    repeat (2) @(posedge i_clk);
    for (s = 0; s < 4; s = s + 1) begin
      sel <= s[1:0];
      m = (s == 0) ? 1 : (s == 1) ? 4 : (s == 2) ? 8 : 16;
      for (n = 0; n < m; n = n + 1) begin
        d = $random(seed);
        rxq.push_back(d);
        chk(rts_b, 1'b0);
        i_peer.send(d);
      end
      repeat (8) @(posedge i_clk);
      chk(rts_b, 1'b1);
      for (n = 0; n < m; n = n + 1) begin
        pulse(5'h01);
        while (rx_valid !== 1'b1) @(posedge i_clk);
        chk(rx_buf, rxq.pop_front());
      end
      repeat (8) @(posedge i_clk);
      chk(rts_b, 1'b0);
    end
    $display("test 5 done");
    arts <= 1'b0;
    irq_en <= 4'h8;
    modem <= ~modem;
    repeat (6) @(posedge i_clk);
    chk({irq, ident, modem_status_reg}, {1'b1, `IID_MODEM, 4'hf});
    pulse(5'h04);
    repeat (3) @(posedge i_clk);
    chk({irq, modem_status_reg}, 5'h00);
    d = $random(seed);
    mcr_d <= d[3:0];
    pulse(5'h08);
    repeat (2) @(posedge i_clk);
    chk({modem_control_reg, rts_b}, {d[3:0], ~d[1]});
    $display("test 6 done");
    test_done;
  end
endmodule // testbench
bind uart_event_timing uart_event_timing_sva i_uart_event_timing_sva (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_fifo_enable_bit(i_fifo_enable_bit),
  .i_dma_mode_bit(i_dma_mode_bit), .i_rx_thresh_sel(i_rx_thresh_sel),
  .i_auto_rts_en(i_auto_rts_en), .i_auto_cts_en(i_auto_cts_en), .i_irq_enable(i_irq_enable),
  .i_tx_holding_wr(i_tx_holding_wr), .i_rx_buffer_read_strobe(i_rx_buffer_read_strobe),
  .i_modem_in(i_modem_in), .o_irq_ident_reg(o_irq_ident_reg), .o_rx_data_ready(o_rx_data_ready),
  .o_tx_holding_empty(o_tx_holding_empty), .o_irq_out(o_irq_out),
  .o_rx_ready_pin_b(o_rx_ready_pin_b), .o_tx_ready_pin_b(o_tx_ready_pin_b),
  .o_serial_out(o_serial_out), .o_rts_b(o_rts_b));
